// >>> verilog/dpts_params.svh
/*
 * Constants of the debug-port transfer sequencer: pin encodings, word kinds,
 * status codes and timing figures.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef DPTS_PARAMS_SVH
`define DPTS_PARAMS_SVH

// freeze indication on the two pipeline flag pins
`define DPTS_FREEZE_CODE 2'h3

// kind of word shifted in, as decoded by the serial framer
`define DPTS_KIND_INSTR 2'h0
`define DPTS_KIND_CPU_DATA 2'h1
`define DPTS_KIND_TRAP_CTRL 2'h2

// status shifted out
`define DPTS_STAT_NULL 2'h0
`define DPTS_STAT_DATA 2'h1
`define DPTS_STAT_EXCEPTION 2'h2
`define DPTS_STAT_SEQ_ERROR 2'h3

// one-hot step codes
`define DPTS_STEP1 5'h01
`define DPTS_STEP2 5'h02
`define DPTS_STEP3 5'h04
`define DPTS_STEP4 5'h08
`define DPTS_STEP5 5'h10

// shortened data returned during a trap enable control transmission
`define DPTS_SHORT_W 7

// least processor clocks between a port write instruction and the next start bit
`define DPTS_WRITE_SETTLE_CYC 4

`define DPTS_DATA_W 32
`define DPTS_TRAP_W 8

`endif

// >>> verilog/dpts_pkg.sv
/*
 * Types of the debug-port transfer sequencer.
 * Assumes dpts_params.svh is on the include path.
 */
`include "dpts_params.svh"

package dpts_pkg;

   typedef enum logic [4:0] {
      STEP1 = `DPTS_STEP1,
      STEP2 = `DPTS_STEP2,
      STEP3 = `DPTS_STEP3,
      STEP4 = `DPTS_STEP4,
      STEP5 = `DPTS_STEP5
   } step_t;

   typedef enum logic [1:0] {
      KIND_INSTR = `DPTS_KIND_INSTR,
      KIND_CPU_DATA = `DPTS_KIND_CPU_DATA,
      KIND_TRAP_CTRL = `DPTS_KIND_TRAP_CTRL
   } kind_t;

   typedef enum logic [1:0] {
      STAT_NULL = `DPTS_STAT_NULL,
      STAT_DATA = `DPTS_STAT_DATA,
      STAT_EXCEPTION = `DPTS_STAT_EXCEPTION,
      STAT_SEQ_ERROR = `DPTS_STAT_SEQ_ERROR
   } status_t;

endpackage : dpts_pkg

// >>> verilog/debug_port_transfer_sequencer.sv
/*
 * Debug-port transfer sequencer: decides, per completed serial transmission,
 * what the shifted-in word does and which status the next transmission returns.
 * Assumes a framer on link_clk_i delivering whole words, and a CPU core on
 * core_clk_i that classifies each passed instruction with a done pulse.
 */
// Overview of operation
// - step sequence applies only while freeze shown
// - debug mode entry starts at step 1
// - status out selected by previous word
// - plain instruction in 1/3: execute, step 1
// - port read instruction: go to step 2
// - port write instruction: go to step 3
// - instruction exception: go to step 4
// - data in 1/3: error fetch, step 5
// - trap control in 1: update, stay 1
// - instruction in 2: error read, step 5
// - data in 2: hand to CPU, step 1
// - trap control in 2: update, stay 2
// - step 3 returns CPU data, short on trap
// - step 4: exception status, ignore, step 1
// - step 5: sequence error, ignore, step 4
// - steps 1, 2 return null status
// - outside debug: only trap control accepted
`timescale 1ns/1ps
`include "dpts_params.svh"

module debug_port_transfer_sequencer #(
   parameter int DATA_W = `DPTS_DATA_W,
   parameter int TRAP_W = `DPTS_TRAP_W
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] pipeline_flag_pins_i,
   // link side, framer on the tool's clock
   input wire logic link_clk_i,
   input wire logic link_word_valid_i,
   input wire logic [1:0] link_word_kind_i,
   input wire logic [DATA_W-1:0] link_word_i,
   output logic port_serial_out_o,
   output logic [1:0] link_status_o,
   output logic [DATA_W-1:0] link_data_o,
   output logic [`DPTS_SHORT_W-1:0] link_short_data_o,
   // CPU side
   output logic cpu_instr_valid_o,
   output logic [DATA_W-1:0] cpu_instr_o,
   input wire logic cpu_done_i,
   input wire logic cpu_reads_port_i,
   input wire logic cpu_writes_port_i,
   input wire logic cpu_exception_i,
   input wire logic [DATA_W-1:0] cpu_write_data_i,
   output logic cpu_rdata_valid_o,
   output logic [DATA_W-1:0] cpu_rdata_o,
   output logic cpu_fetch_error_o,
   output logic [TRAP_W-1:0] trap_enable_ctrl_reg_o,
   output logic [4:0] step_o
);

   // ---------------- link domain ----------------
   logic lrst_meta_reg, lrst_n_reg;
   logic link_req_reg;
   logic [1:0] link_kind_reg;
   logic [DATA_W-1:0] link_word_reg;
   logic ack_meta_reg, ack_sync_reg, ack_seen_reg;
   // handshake and answer from the core, read here only after the toggle settles
   logic ack_tgl_reg;
   logic [1:0] next_status_reg;
   logic [DATA_W-1:0] next_data_reg;

   // core reset brought into the link domain
   always_ff @(posedge link_clk_i) begin
      lrst_meta_reg <= rst_n_i;
      lrst_n_reg <= lrst_meta_reg;
   end

   always_ff @(posedge link_clk_i) begin
      if (!lrst_n_reg) begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else begin
         ack_meta_reg <= ack_tgl_reg;
         ack_sync_reg <= ack_meta_reg;
         ack_seen_reg <= ack_sync_reg;
      end
   end

   // word capture; held stable until the core answers
   always_ff @(posedge link_clk_i) begin
      if (!lrst_n_reg) begin
         link_req_reg <= 1'b0;
         link_kind_reg <= `DPTS_KIND_INSTR;
         link_word_reg <= '0;
      end else if (link_word_valid_i && port_serial_out_o) begin
         link_req_reg <= ~link_req_reg;
         link_kind_reg <= link_word_kind_i;
         link_word_reg <= link_word_i;
      end
   end

   // ready and the status for the next transmission
   always_ff @(posedge link_clk_i) begin
      if (!lrst_n_reg) begin
         port_serial_out_o <= 1'b1;
         link_status_o <= `DPTS_STAT_NULL;
         link_data_o <= '0;
         link_short_data_o <= '0;
      end else if (ack_sync_reg != ack_seen_reg) begin
         port_serial_out_o <= 1'b1;
         link_status_o <= next_status_reg;
         link_data_o <= next_data_reg;
         link_short_data_o <= next_data_reg[DATA_W-1 -: `DPTS_SHORT_W];
      end else if (link_word_valid_i && port_serial_out_o) begin
         port_serial_out_o <= 1'b0;
      end
   end

   // ---------------- core domain ----------------
   logic req_meta_reg, req_sync_reg, req_seen_reg;
   logic busy_reg;
   logic idle_err_reg;
   logic [DATA_W-1:0] port_data_reg;
   dpts_pkg::step_t step_reg;
   dpts_pkg::step_t step_next;
   logic freeze, word_evt, finish, trap_wr;
   dpts_pkg::kind_t kind;

   assign freeze = (pipeline_flag_pins_i == `DPTS_FREEZE_CODE);
   assign word_evt = (req_sync_reg != req_seen_reg) && !busy_reg;
   assign kind = dpts_pkg::kind_t'(link_kind_reg);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
      end else begin
         req_meta_reg <= link_req_reg;
         req_sync_reg <= req_meta_reg;
      end
   end

   // step decision for the word in hand; instructions in steps 1 and 3 under freeze wait for the CPU verdict
   always_comb begin
      step_next = step_reg;
      finish = 1'b0;
      trap_wr = 1'b0;
      if (busy_reg) begin
         finish = cpu_done_i;
         if (cpu_exception_i) begin
            step_next = dpts_pkg::STEP4;
         end else if (cpu_reads_port_i) begin
            step_next = dpts_pkg::STEP2;
         end else if (cpu_writes_port_i) begin
            step_next = dpts_pkg::STEP3;
         end else begin
            step_next = dpts_pkg::STEP1;
         end
      end else if (word_evt) begin
         finish = 1'b1;
         if (!freeze) begin
            step_next = dpts_pkg::STEP1;
            trap_wr = (kind == dpts_pkg::KIND_TRAP_CTRL) && !idle_err_reg;
         end else begin
            unique case (step_reg)
               dpts_pkg::STEP1, dpts_pkg::STEP3: begin
                  if (kind == dpts_pkg::KIND_INSTR) begin
                     finish = 1'b0;
                  end else if (kind == dpts_pkg::KIND_CPU_DATA) begin
                     step_next = dpts_pkg::STEP5;
                  end else begin
                     step_next = dpts_pkg::STEP1;
                     trap_wr = 1'b1;
                  end
               end
               dpts_pkg::STEP2: begin
                  if (kind == dpts_pkg::KIND_INSTR) begin
                     step_next = dpts_pkg::STEP5;
                  end else if (kind == dpts_pkg::KIND_CPU_DATA) begin
                     step_next = dpts_pkg::STEP1;
                  end else begin
                     trap_wr = 1'b1;
                  end
               end
               dpts_pkg::STEP4: step_next = dpts_pkg::STEP1;
               dpts_pkg::STEP5: step_next = dpts_pkg::STEP4;
               default: step_next = dpts_pkg::STEP1;
            endcase
         end
      end
   end

   // step register; outside freeze it sits at step 1 so entry starts there
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         step_reg <= dpts_pkg::STEP1;
      end else if (!freeze && !busy_reg) begin
         step_reg <= dpts_pkg::STEP1;
      end else if (finish) begin
         step_reg <= step_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         busy_reg <= 1'b0;
         req_seen_reg <= 1'b0;
      end else if (word_evt) begin
         req_seen_reg <= req_sync_reg;
         busy_reg <= !finish;
      end else if (busy_reg && cpu_done_i) begin
         busy_reg <= 1'b0;
      end
   end

   // outside freeze a non-trap word latches a sequence error; the word after it is ignored
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         idle_err_reg <= 1'b0;
      end else if (freeze) begin
         idle_err_reg <= 1'b0;
      end else if (word_evt) begin
         idle_err_reg <= !idle_err_reg && (kind != dpts_pkg::KIND_TRAP_CTRL);
      end
   end

   // status for the next transmission follows from the step reached, outside freeze from trap_wr and idle_err_reg
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ack_tgl_reg <= 1'b0;
         next_status_reg <= `DPTS_STAT_NULL;
         next_data_reg <= '0;
      end else if (finish) begin
         ack_tgl_reg <= ~ack_tgl_reg;
         // a port write finishing now has not reached port_data_reg yet
         if (busy_reg && cpu_done_i && cpu_writes_port_i) begin
            next_data_reg <= cpu_write_data_i;
         end else begin
            next_data_reg <= port_data_reg;
         end
         if (!freeze && !busy_reg) begin
            next_status_reg <= (trap_wr || idle_err_reg) ? `DPTS_STAT_NULL : `DPTS_STAT_SEQ_ERROR;
         end else begin
            unique case (step_next)
               dpts_pkg::STEP1, dpts_pkg::STEP2: next_status_reg <= `DPTS_STAT_NULL;
               dpts_pkg::STEP3: next_status_reg <= `DPTS_STAT_DATA;
               dpts_pkg::STEP4: next_status_reg <= `DPTS_STAT_EXCEPTION;
               dpts_pkg::STEP5: next_status_reg <= `DPTS_STAT_SEQ_ERROR;
               default: next_status_reg <= `DPTS_STAT_NULL;
            endcase
         end
      end
   end

   // CPU writes to the port data register; the data rides in the answer
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         port_data_reg <= '0;
      end else if (busy_reg && cpu_done_i && cpu_writes_port_i) begin
         port_data_reg <= cpu_write_data_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         trap_enable_ctrl_reg_o <= '0;
      end else if (trap_wr) begin
         trap_enable_ctrl_reg_o <= link_word_reg[TRAP_W-1:0];
      end
   end

   // one-cycle strobes towards the CPU
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cpu_instr_valid_o <= 1'b0;
         cpu_instr_o <= '0;
         cpu_rdata_valid_o <= 1'b0;
         cpu_rdata_o <= '0;
         cpu_fetch_error_o <= 1'b0;
      end else begin
         cpu_instr_valid_o <= word_evt && freeze && !finish;
         cpu_rdata_valid_o <= word_evt && freeze && step_reg == dpts_pkg::STEP2
            && kind == dpts_pkg::KIND_CPU_DATA;
         cpu_fetch_error_o <= word_evt && freeze && step_next == dpts_pkg::STEP5
            && (step_reg != dpts_pkg::STEP5);
         if (word_evt) begin
            cpu_instr_o <= link_word_reg;
            cpu_rdata_o <= link_word_reg;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         step_o <= `DPTS_STEP1;
      end else begin
         step_o <= step_reg;
      end
   end

endmodule : debug_port_transfer_sequencer

// >>> tb/dpts_sva.sv
/* Port checker of the transfer sequencer.
   Assumes it is bound into debug_port_transfer_sequencer. */
`timescale 1ns/1ps
module dpts_sva #(
   parameter int DATA_W = 32
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic [1:0] pipeline_flag_pins_i,
   input wire logic link_word_valid_i,
   input wire logic port_serial_out_o,
   input wire logic [1:0] link_status_o,
   input wire logic [DATA_W-1:0] link_data_o,
   input wire logic [6:0] link_short_data_o,
   input wire logic cpu_instr_valid_o,
   input wire logic cpu_rdata_valid_o,
   input wire logic cpu_fetch_error_o,
   input wire logic [4:0] step_o
);
   sequence leave_s4;
      step_o == 5'h08 ##1 step_o != 5'h08;
   endsequence
   sequence leave_s5;
      step_o == 5'h10 ##1 step_o != 5'h10;
   endsequence
   reset_step_a: assert property (@(posedge core_clk_i) !rst_n_i ##1 !rst_n_i |-> step_o == 5'h01)
      else $error("step not 1 in reset");
   step_onehot_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) $onehot(step_o))
      else $error("step not one-hot");
   exc_to_one_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) leave_s4 |-> step_o == 5'h01)
      else $error("step 4 left wrongly");
   seq_to_exc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) leave_s5 |->
      step_o == 5'h08 || $past(pipeline_flag_pins_i) != 2'h3 || $past(pipeline_flag_pins_i, 2) != 2'h3)
      else $error("step 5 left wrongly");
   no_freeze_cpu_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      pipeline_flag_pins_i != 2'h3 ##1 pipeline_flag_pins_i != 2'h3 |-> !cpu_instr_valid_o)
      else $error("instruction passed outside freeze");
   fetch_err_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      cpu_fetch_error_o |-> ##[0:3] step_o == 5'h10)
      else $error("fetch error without step 5");
   rdata_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      cpu_rdata_valid_o |-> ##[0:3] step_o == 5'h01)
      else $error("read data without step 1");
   taken_busy_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
      link_word_valid_i && port_serial_out_o |=> !port_serial_out_o)
      else $error("ready kept after word");
   status_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
      !port_serial_out_o ##1 !port_serial_out_o |-> $stable(link_status_o))
      else $error("status moved while busy");
   short_top_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
      link_short_data_o == link_data_o[DATA_W-1 -: 7])
      else $error("short data not top bits");
endmodule : dpts_sva

bind debug_port_transfer_sequencer dpts_sva #(.DATA_W(DATA_W)) sva_u (.core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .pipeline_flag_pins_i(pipeline_flag_pins_i),
   .link_word_valid_i(link_word_valid_i), .port_serial_out_o(port_serial_out_o),
   .link_status_o(link_status_o), .link_data_o(link_data_o), .link_short_data_o(link_short_data_o),
   .cpu_instr_valid_o(cpu_instr_valid_o), .cpu_rdata_valid_o(cpu_rdata_valid_o),
   .cpu_fetch_error_o(cpu_fetch_error_o), .step_o(step_o));

// >>> tb/dev_tool_model.sv
/* Development tool on the link: one word per ready.
   Assumes a running link clock and the sequencer's ready output. */
`timescale 1ns/1ps
module dev_tool_model (
   input wire logic link_clk_i,
   input wire logic port_serial_out_i,
   output logic link_word_valid_o,
   output logic [1:0] link_word_kind_o,
   output logic [31:0] link_word_o
);
   initial begin
      link_word_valid_o = 1'b0;
      link_word_kind_o = 2'h3;
      link_word_o = 32'h0;
   end
   task automatic send(input logic [1:0] kind, input logic [31:0] word);
      int n;
      n = 0;
      @(negedge link_clk_i);
      while (port_serial_out_i !== 1'b1 && n < 400) begin
         @(negedge link_clk_i);
         n++;
      end
      link_word_valid_o = 1'b1;
      link_word_kind_o = kind;
      link_word_o = word;
      @(negedge link_clk_i);
      link_word_valid_o = 1'b0;
      link_word_kind_o = ~kind;
      link_word_o = ~word;
      // next word only after ready, so the write settle time is kept
      while (port_serial_out_i !== 1'b1 && n < 400) begin
         @(negedge link_clk_i);
         n++;
      end
   endtask : send
endmodule : dev_tool_model

// >>> tb/debug_port_transfer_sequencer_tb.sv
/* Bench of the transfer sequencer; the cpu is answered here.
   Assumes the design, checker and tool model are compiled first. */
`timescale 1ns/1ps
module debug_port_transfer_sequencer_tb;
   logic core_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [1:0] flags = 2'h3;
   logic done = 1'b0, rd = 1'b0, wr = 1'b0, exc = 1'b0, valid, ready, ivalid, rvalid, ferr;
   logic [1:0] kind, status, cls;
   logic [31:0] word, ldata, instr, rdata, wdata = 32'h0;
   logic [6:0] short;
   logic [7:0] trap;
   logic [4:0] step;
   int failures = 0;
   int cmp_count = 0;
   int seen = 0;
   debug_port_transfer_sequencer dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .pipeline_flag_pins_i(flags), .link_clk_i(link_clk_i), .link_word_valid_i(valid),
      .link_word_kind_i(kind), .link_word_i(word), .port_serial_out_o(ready), .link_status_o(status),
      .link_data_o(ldata), .link_short_data_o(short), .cpu_instr_valid_o(ivalid), .cpu_instr_o(instr),
      .cpu_done_i(done), .cpu_reads_port_i(rd), .cpu_writes_port_i(wr), .cpu_exception_i(exc),
      .cpu_write_data_i(wdata), .cpu_rdata_valid_o(rvalid), .cpu_rdata_o(rdata),
      .cpu_fetch_error_o(ferr), .trap_enable_ctrl_reg_o(trap), .step_o(step));
   dev_tool_model tool_u (.link_clk_i(link_clk_i), .port_serial_out_i(ready),
      .link_word_valid_o(valid), .link_word_kind_o(kind), .link_word_o(word));
   initial forever #4 core_clk_i = ~core_clk_i;
   initial begin
      #3;
      forever #24 link_clk_i = ~link_clk_i;
   end
   // cpu classifies each passed instruction three cycles later
   always @(negedge core_clk_i) begin
      if (ivalid === 1'b1) begin
         seen++;
         repeat (3) @(negedge core_clk_i);
         {exc, rd, wr, done} = {cls == 2'h3, cls == 2'h1, cls == 2'h2, 1'b1};
         @(negedge core_clk_i);
         done = 1'b0;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one transmission; n is the step reached, which selects the status
   task automatic xfer(input logic [1:0] k, input logic [31:0] w, input logic [1:0] c, input int n);
      cls = c;
      tool_u.send(k, w);
      repeat (2) @(negedge core_clk_i);
      chk(status, (n < 3) ? 0 : n - 2);
      chk(step, 1 << (n - 1));
   endtask : xfer
   task automatic t_write;
      wdata = 32'hA5C3_1E0F;
      xfer(2'h0, 32'h7C00_03A6, 2'h2, 3);
      chk(ldata, wdata);
      chk(short, 7'h52);
      wdata = 32'h1234_5678;
      xfer(2'h0, 32'h7C00_03A6, 2'h2, 3);
      xfer(2'h2, 32'h0000_005A, 2'h0, 1);
      chk({short, trap}, {7'h09, 8'h5A});
   endtask : t_write
   task automatic t_read;
      xfer(2'h0, 32'h7C00_02A6, 2'h1, 2);
      xfer(2'h2, 32'h0000_0033, 2'h0, 2);
      xfer(2'h1, 32'hCAFE_0001, 2'h0, 1);
      chk(rdata, 32'hCAFE_0001);
      chk(trap, 8'h33);
      xfer(2'h0, 32'h7C00_02A6, 2'h1, 2);
      seen = 0;
      xfer(2'h0, 32'h6000_0000, 2'h0, 5);
      chk(seen, 0);
      xfer(2'h1, 32'h0, 2'h0, 4);
      xfer(2'h2, 32'hFF, 2'h0, 1);
      chk(trap, 8'h33);
   endtask : t_read
   task automatic t_misc;
      xfer(2'h0, 32'h6000_0000, 2'h0, 1);
      chk(instr, 32'h6000_0000);
      xfer(2'h0, 32'h7FE0_0008, 2'h3, 4);
      xfer(2'h0, 32'h0, 2'h0, 1);
      xfer(2'h2, 32'hC3, 2'h0, 1);
      chk(trap, 8'hC3);
      xfer(2'h1, 32'h0, 2'h0, 5);
      xfer(2'h0, 32'h0, 2'h0, 4);
      xfer(2'h0, 32'h0, 2'h0, 1);
      xfer(2'h0, 32'h7C00_03A6, 2'h2, 3);
      xfer(2'h1, 32'h0, 2'h0, 5);
      xfer(2'h0, 32'h0, 2'h0, 4);
      xfer(2'h0, 32'h0, 2'h0, 1);
   endtask : t_misc
   task automatic t_nofreeze;
      flags = 2'h0;
      seen = 0;
      tool_u.send(2'h0, 32'h6000_0000);
      chk({status, step, seen[3:0]}, {2'h3, 5'h01, 4'h0});
      tool_u.send(2'h2, 32'h81);
      chk({status, trap}, {2'h0, 8'h33});
      tool_u.send(2'h2, 32'h81);
      chk({status, trap}, {2'h0, 8'h81});
      @(negedge core_clk_i);
      flags = 2'h3;
      xfer(2'h0, 32'h6000_0000, 2'h0, 1);
   endtask : t_nofreeze
   initial begin
      repeat (20) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      repeat (20) @(negedge core_clk_i);
      chk({ready, status, trap, step}, {1'b1, 2'h0, 8'h00, 5'h01});
      t_misc;
      t_write;
      t_read;
      t_nofreeze;
      print_verdict;
   end
   initial begin
      #100us;
      failures++;
      print_verdict;
   end
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
endmodule : debug_port_transfer_sequencer_tb
